// >>> test/csfr_bank_props.sv
// Checker of the SFR bank port behaviour
`timescale 1ns/10ps
module csfr_bank_props (
    input wire I_CLOCK, I_RST, I_CE, I_WR, I_RD, I_PUSH,
    input wire [7:0] I_ADDR, I_WDATA, I_PUSH_DATA, O_RDATA,
    input wire O_RAM_WR, O_BAUD_DOUBLE_ENABLE, I_BAUD_FROM_TIMER1,
    input wire O_BAUD_DOUBLED,
    input wire [7:0] O_RAM_ADDR, O_RAM_WDATA, O_PORT_ZERO_PINS,
    input wire [7:0] O_WAKE_RELOAD_VALUE,
    input wire [1:0] I_SERIAL_MODE
);
    default clocking @(posedge I_CLOCK); endclocking
    default disable iff (I_RST);
    wire wr_en = I_CE && I_WR;
    wire push_en = I_CE && I_PUSH;
    // ==========================================================
    // Properties
    property p_port_wr;
        wr_en && I_ADDR == 8'h80 |=> O_PORT_ZERO_PINS == $past(I_WDATA);
    endproperty
    a_port_wr: assert property (p_port_wr) else $error("port lost");
    property p_port_rd;
        I_CE && I_RD && I_ADDR == 8'h80 |=> O_RDATA == $past(O_PORT_ZERO_PINS);
    endproperty
    a_port_rd: assert property (p_port_rd) else $error("port read");
    property p_wake_wr;
        wr_en && I_ADDR == 8'h86 |=> O_WAKE_RELOAD_VALUE == $past(I_WDATA);
    endproperty
    a_wake_wr: assert property (p_wake_wr) else $error("reload");
    property p_push;
        push_en |=> O_RAM_WR && O_RAM_WDATA == $past(I_PUSH_DATA);
    endproperty
    a_push: assert property (p_push) else $error("push lost");
    property p_no_push;
        I_CE && !I_PUSH |=> !O_RAM_WR;
    endproperty
    a_no_push: assert property (p_no_push) else $error("stray write");
    property p_push_inc;
        push_en ##1 push_en |=> O_RAM_ADDR == $past(O_RAM_ADDR) + 8'h01;
    endproperty
    a_push_inc: assert property (p_push_inc) else $error("no incr");
    property p_baud_bit;
        wr_en && I_ADDR == 8'h87 |=> O_BAUD_DOUBLE_ENABLE == $past(I_WDATA[7]);
    endproperty
    a_baud_bit: assert property (p_baud_bit) else $error("baud bit");
    property p_baud;
        O_BAUD_DOUBLED == (O_BAUD_DOUBLE_ENABLE && (I_SERIAL_MODE == 2'h2
            || I_SERIAL_MODE[0] && I_BAUD_FROM_TIMER1));
    endproperty
    a_baud: assert property (p_baud) else $error("baud doubling");
    c_push2: cover property (push_en ##1 push_en);
    c_read: cover property (I_RD && I_ADDR == 8'h80);
    c_baud: cover property (O_BAUD_DOUBLED);
endmodule // csfr_bank_props

bind csfr_bank csfr_bank_props u_props (.I_CLOCK, .I_RST, .I_CE, .I_WR,
    .I_RD, .I_PUSH, .I_ADDR, .I_WDATA, .I_PUSH_DATA, .O_RDATA, .O_RAM_WR,
    .O_BAUD_DOUBLE_ENABLE, .I_BAUD_FROM_TIMER1, .O_BAUD_DOUBLED,
    .O_RAM_ADDR, .O_RAM_WDATA, .O_PORT_ZERO_PINS, .O_WAKE_RELOAD_VALUE,
    .I_SERIAL_MODE);

// >>> test/csfr_bank_test.sv
// Self-checking testbench of the SFR bank
`timescale 1ns/10ps
module csfr_bank_test;
    reg clk = 0, rst = 1, ce = 1, wr = 0, rd = 0, push = 0, pop = 0;
    reg ld = 0, src = 0;
    reg [1:0] mode = 0;
    reg [7:0] addr = 0, wd = 0, pd = 0, v, w;
    reg [15:0] lv = 0;
    wire [7:0] rdata, radr, rwd, p0, rl;
    wire rwr, ben, bdb;
    wire [15:0] data_pointer_main;
    integer err_count = 0, n_compared = 0, i;
`define CHK(a, e) begin n_compared = n_compared + 1; if ((a) !== (e)) begin \
    $display("CHECK FAILED t=%0t got %h exp %h", $time, a, e); \
    err_count = err_count + 1; end end
    csfr_bank dut (.I_CLOCK(clk), .I_RST(rst), .I_CE(ce), .I_ADDR(addr),
        .I_WDATA(wd), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_PUSH(push),
        .I_PUSH_DATA(pd), .I_POP(pop), .O_RAM_WR(rwr), .O_RAM_ADDR(radr),
        .O_RAM_WDATA(rwd), .I_DATA_POINTER_MAIN_LOAD(ld), .I_DATA_POINTER_MAIN_VALUE(lv),
        .O_DATA_POINTER_MAIN(data_pointer_main), .O_PORT_ZERO_PINS(p0), .O_WAKE_RELOAD_VALUE(rl),
        .O_BAUD_DOUBLE_ENABLE(ben), .O_FRAMING_FLAG_ACCESS_ENABLE(),
        .O_POWER_DOWN_REQUEST(), .O_SLEEP_CLOCK_GATE_REQUEST(),
        .I_SERIAL_MODE(mode), .I_BAUD_FROM_TIMER1(src), .O_BAUD_DOUBLED(bdb));
    always #5 clk = ~clk;
    function exp_baud(input s, input [1:0] m, input t);
        exp_baud = s & (m == 2'h2 | (m[0] & t));
    endfunction
    // ==========================================================
    // Bus cycle: write, or read compared with d
    task bus(input w_n, input [7:0] a, input [7:0] d);
        begin
            @(posedge clk);
            addr <= a;
            wd <= d;
            wr <= w_n;
            rd <= !w_n;
            @(posedge clk);
            wr <= 1'h0;
            rd <= 1'h0;
            #1;
            if (!w_n) `CHK(rdata, d)
        end
    endtask
    task pulse(input u, input o, input l, input [7:0] d);
        begin
            @(posedge clk);
            {push, pop, ld, pd, lv} <= {u, o, l, d, d, d ^ 8'h5A};
            @(posedge clk);
            {push, pop, ld} <= 3'h0;
            #1;
        end
    endtask
    task tally_and_finish;
        begin
            $display("compared %0d mismatched %0d", n_compared, err_count);
            if (err_count == 0 && n_compared > 0)
                $display("No errors found");
            else
                $display("Errors were found");
            $finish;
        end
    endtask
    initial begin
        repeat (5000) @(posedge clk);
        err_count = err_count + 1;
        tally_and_finish;
    end
    // ==========================================================
    // Tests
    initial begin
        v = $urandom(32'hD30CA47C);
        repeat (10) @(posedge clk);
        rst <= 1'h0;
        bus(0, 8'h80, 8'hFF);
        bus(0, 8'h81, 8'h07);
        bus(0, 8'h82, 8'h00);
        bus(0, 8'h83, 8'h00);
        bus(0, 8'h86, 8'h00);
        pulse(1, 0, 0, 8'h3C);
        `CHK({rwr, radr, rwd}, {1'h1, 8'h08, 8'h3C})
        bus(0, 8'h81, 8'h08);
        $display("test reset_values done");
        for (i = 0; i < 24; i = i + 1) begin
            v = $urandom;
            w = $urandom;
            if (w == 8'hFF) w = 8'hFE;
            bus(1, 8'h80, v);
            bus(1, 8'h86, w);
            bus(1, 8'h87, v & 8'hDF);
            `CHK({p0, rl, ben}, {v, w, v[7]})
            bus(0, 8'h80, v);
            bus(0, 8'h86, w);
        end
        $display("test random_registers done");
        for (i = 0; i < 16; i = i + 1) begin
            bus(1, 8'h87, {i[3], 7'h00});
            @(posedge clk);
            {mode, src} <= {i[1:0], i[2]};
            #2 `CHK(bdb, exp_baud(i[3], i[1:0], i[2]))
        end
        $display("test baud_doubling done");
        bus(1, 8'h82, v);
        bus(1, 8'h83, w);
        `CHK(data_pointer_main, {w, v})
        bus(1, 8'hA2, 8'h01);
        `CHK(data_pointer_main, 16'h0000)
        pulse(0, 0, 1, 8'hC3);
        bus(0, 8'h82, 8'h99);
        bus(1, 8'hA2, 8'h00);
        `CHK(data_pointer_main, {w, v})
        $display("test pointer_banks done");
        bus(1, 8'h81, 8'hFE);
        @(posedge clk);
        {push, pd} <= {1'h1, 8'hA1};
        @(posedge clk);
        pd <= 8'hB2;
        #1 `CHK({rwr, radr, rwd}, {1'h1, 8'hFF, 8'hA1})
        @(posedge clk);
        push <= 1'h0;
        #1 `CHK({rwr, radr, rwd}, {1'h1, 8'h00, 8'hB2})
        pulse(0, 1, 0, 8'h00);
        bus(0, 8'h81, 8'hFF);
        ce <= 1'h0;
        bus(1, 8'h80, ~v);
        ce <= 1'h1;
        `CHK(p0, v)
        $display("test stack_wrap done");
        tally_and_finish;
    end
endmodule // csfr_bank_test

// >>> verilog/csfr_bank.v
// Low-address special function register bank of the core
//
// Behaviour
// - Port 0 latch is an 8-bit read/write register resetting to all ones.
// - A push or call first increments the stack pointer, then writes RAM.
// - The stack pointer resets to 07h so the first push lands at 08h.
// - Two pointer bytes resetting to zero form one 16-bit data pointer.
// - Bank select bit 0 of auxiliary control one picks the active pointer.
// - The wake timer reload register holds the 8-bit restart value.
// - Baud double bit 7 of power control doubles serial port 0 baud rate in mode 2, or in modes 1 and 3 when timer 1 sets the rate.
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/10ps
`include "csfr_consts.vh"

module csfr_bank (
    // Clock, reset, enable
    input wire I_CLOCK,
    input wire I_RST,
    input wire I_CE,
    // Register port
    input wire [7:0] I_ADDR,
    input wire [7:0] I_WDATA,
    input wire I_WR,
    input wire I_RD,
    output reg [7:0] O_RDATA,
    // Stack operations from the core
    input wire I_PUSH,
    input wire [7:0] I_PUSH_DATA,
    input wire I_POP,
    output reg O_RAM_WR,
    output reg [7:0] O_RAM_ADDR,
    output reg [7:0] O_RAM_WDATA,
    // Data pointer
    input wire I_DATA_POINTER_MAIN_LOAD,
    input wire [15:0] I_DATA_POINTER_MAIN_VALUE,
    output wire [15:0] O_DATA_POINTER_MAIN,
    // Port 0 and peripheral controls
    output wire [7:0] O_PORT_ZERO_PINS,
    output wire [7:0] O_WAKE_RELOAD_VALUE,
    output wire O_BAUD_DOUBLE_ENABLE,
    output wire O_FRAMING_FLAG_ACCESS_ENABLE,
    output wire O_POWER_DOWN_REQUEST,
    output wire O_SLEEP_CLOCK_GATE_REQUEST,
    // Serial port 0 baud qualification
    input wire [1:0] I_SERIAL_MODE,
    input wire I_BAUD_FROM_TIMER1,
    output wire O_BAUD_DOUBLED
);

    reg [7:0] port0_q;
    reg [7:0] stack_q;
    reg [7:0] wake_reload_q;
    reg [7:0] power_q;
    reg [7:0] aux_one_q;
    reg [7:0] rdata_d;
    reg [7:0] stack_d;
    wire [15:0] data_pointer_main;
    wire hit_port0;
    wire hit_stack;
    wire hit_dplow;
    wire hit_dphigh;
    wire hit_wake;
    wire hit_power;
    wire hit_aux;
    wire wr_port0;
    wire wr_stack;
    wire wr_dplow;
    wire wr_dphigh;
    wire wr_wake;
    wire wr_power;
    wire wr_aux;
    wire bank_sel;
    wire [7:0] power_view;
    wire [7:0] aux_view;
    wire mode_two;
    wire mode_timer;
    wire baud_qualified;

    // ==========================================================
    // Address decode, shared by the write and the read paths
    assign hit_port0 = (I_ADDR == `CSFR_ADDR_PORT0);
    assign hit_stack = (I_ADDR == `CSFR_ADDR_STACK);
    assign hit_dplow = (I_ADDR == `CSFR_ADDR_DPLOW);
    assign hit_dphigh = (I_ADDR == `CSFR_ADDR_DPHIGH);
    assign hit_wake = (I_ADDR == `CSFR_ADDR_WAKE_RELOAD);
    assign hit_power = (I_ADDR == `CSFR_ADDR_POWER);
    assign hit_aux = (I_ADDR == `CSFR_ADDR_AUX_ONE);

    // ==========================================================
    // Write decode
    assign wr_port0 = I_WR && hit_port0;
    assign wr_stack = I_WR && hit_stack;
    assign wr_dplow = I_WR && hit_dplow;
    assign wr_dphigh = I_WR && hit_dphigh;
    assign wr_wake = I_WR && hit_wake;
    assign wr_power = I_WR && hit_power;
    assign wr_aux = I_WR && hit_aux;
    assign bank_sel = aux_one_q[`CSFR_BIT_BANK_SELECT];

    // ==========================================================
    // Port 0 output latch
    always @(posedge I_CLOCK or posedge I_RST) begin
        if (I_RST) begin
            port0_q <= `CSFR_RST_PORT0;
        end else if (I_CE) begin
            if (wr_port0) begin
                port0_q <= I_WDATA;
            end
        end
    end

    // ==========================================================
    // Wake timer reload byte
    always @(posedge I_CLOCK or posedge I_RST) begin
        if (I_RST) begin
            wake_reload_q <= `CSFR_RST_WAKE_RELOAD;
        end else if (I_CE) begin
            if (wr_wake) begin
                wake_reload_q <= I_WDATA;
            end
        end
    end

    // ==========================================================
    // Power control
    always @(posedge I_CLOCK or posedge I_RST) begin
        if (I_RST) begin
            power_q <= `CSFR_RST_POWER;
        end else if (I_CE) begin
            if (wr_power) begin
                // Reserved bit 5 stays at its reset value
                power_q <= I_WDATA & `CSFR_POWER_WMASK;
            end
        end
    end

    // ==========================================================
    // Auxiliary control one
    always @(posedge I_CLOCK or posedge I_RST) begin
        if (I_RST) begin
            aux_one_q <= `CSFR_RST_AUX_ONE;
        end else if (I_CE) begin
            if (wr_aux) begin
                // Only the bank select bit is kept
                aux_one_q <= I_WDATA & `CSFR_AUX_WMASK;
            end
        end
    end

    // ==========================================================
    // Read views: reserved bits always read back as zero
    assign power_view = power_q & `CSFR_POWER_WMASK;
    assign aux_view = aux_one_q & `CSFR_AUX_WMASK;

    // ==========================================================
    // Stack pointer: pre-increment on push, post-decrement on pop
    always @* begin
        stack_d = stack_q;
        if (I_PUSH) begin
            stack_d = stack_q + 8'h01;
        end else if (I_POP) begin
            stack_d = stack_q - 8'h01;
        end else if (wr_stack) begin
            stack_d = I_WDATA;
        end
    end

    always @(posedge I_CLOCK or posedge I_RST) begin
        if (I_RST) begin
            stack_q <= `CSFR_RST_STACK;
        end else if (I_CE) begin
            stack_q <= stack_d;
        end
    end

    // ==========================================================
    // Scratch-pad RAM write port
    // Address and data hold the last push so the RAM side sees no glitch
    always @(posedge I_CLOCK or posedge I_RST) begin
        if (I_RST) begin
            O_RAM_WR <= 1'b0;
            O_RAM_ADDR <= 8'h00;
            O_RAM_WDATA <= 8'h00;
        end else if (I_CE) begin
            O_RAM_WR <= I_PUSH;
            if (I_PUSH) begin
                // Data goes to the already incremented address
                O_RAM_ADDR <= stack_d;
                O_RAM_WDATA <= I_PUSH_DATA;
            end
        end
    end

    // ==========================================================
    // Data pointers
    csfr_pointer_bank #(
        .WIDTH(16)
    ) u_pointer_bank (
        .clk(I_CLOCK),
        .rst(I_RST),
        .ce(I_CE),
        .bank_sel(bank_sel),
        .wr_low(wr_dplow),
        .wr_high(wr_dphigh),
        .wdata(I_WDATA),
        .load(I_DATA_POINTER_MAIN_LOAD),
        .load_value(I_DATA_POINTER_MAIN_VALUE),
        .ptr(data_pointer_main)
    );
    assign O_DATA_POINTER_MAIN = data_pointer_main;

    // ==========================================================
    // Read decode; unmapped addresses read zero
    always @* begin
        if (hit_port0) begin
            rdata_d = port0_q;
        end else if (hit_stack) begin
            rdata_d = stack_q;
        end else if (hit_dplow) begin
            rdata_d = data_pointer_main[7:0];
        end else if (hit_dphigh) begin
            rdata_d = data_pointer_main[15:8];
        end else if (hit_wake) begin
            rdata_d = wake_reload_q;
        end else if (hit_power) begin
            rdata_d = power_view;
        end else if (hit_aux) begin
            rdata_d = aux_view;
        end else begin
            rdata_d = 8'h00;
        end
    end

    always @(posedge I_CLOCK or posedge I_RST) begin
        if (I_RST) begin
            O_RDATA <= 8'h00;
        end else if (I_CE) begin
            O_RDATA <= I_RD ? rdata_d : 8'h00;
        end
    end

    // ==========================================================
    // Outputs
    assign O_PORT_ZERO_PINS = port0_q;
    assign O_WAKE_RELOAD_VALUE = wake_reload_q;
    assign O_BAUD_DOUBLE_ENABLE = power_q[`CSFR_BIT_BAUD_DOUBLE];
    assign O_FRAMING_FLAG_ACCESS_ENABLE = power_q[`CSFR_BIT_FRAME_ACCESS];
    assign O_POWER_DOWN_REQUEST = power_q[`CSFR_BIT_POWER_DOWN];
    assign O_SLEEP_CLOCK_GATE_REQUEST = power_q[`CSFR_BIT_SLEEP];

    // ==========================================================
    // Serial port 0 baud doubling
    // Mode 2 always runs from the core clock, so doubling applies
    assign mode_two = (I_SERIAL_MODE == 2'h2);
    // Modes 1 and 3 only double when timer 1 overflow sets the rate
    assign mode_timer = I_SERIAL_MODE[0] && I_BAUD_FROM_TIMER1;
    assign baud_qualified = mode_two || mode_timer;
    assign O_BAUD_DOUBLED = power_q[`CSFR_BIT_BAUD_DOUBLE] &&
        baud_qualified;

endmodule // csfr_bank

// >>> verilog/csfr_consts.vh
// Register offsets, field positions and reset values of the SFR bank
`ifndef CSFR_CONSTS_VH
`define CSFR_CONSTS_VH

// ==========================================================
// Register offsets
`define CSFR_ADDR_PORT0 8'h80
`define CSFR_ADDR_STACK 8'h81
`define CSFR_ADDR_DPLOW 8'h82
`define CSFR_ADDR_DPHIGH 8'h83
`define CSFR_ADDR_WAKE_RELOAD 8'h86
`define CSFR_ADDR_POWER 8'h87
`define CSFR_ADDR_AUX_ONE 8'hA2

// ==========================================================
// Reset values
`define CSFR_RST_PORT0 8'hFF
`define CSFR_RST_STACK 8'h07
`define CSFR_RST_DP 8'h00
`define CSFR_RST_WAKE_RELOAD 8'h00
`define CSFR_RST_POWER 8'h00
`define CSFR_RST_AUX_ONE 8'h00

// ==========================================================
// Field positions
`define CSFR_BIT_BAUD_DOUBLE 7
`define CSFR_BIT_FRAME_ACCESS 6
`define CSFR_BIT_COLD_START 4
`define CSFR_BIT_GFLAG1 3
`define CSFR_BIT_GFLAG0 2
`define CSFR_BIT_POWER_DOWN 1
`define CSFR_BIT_SLEEP 0
`define CSFR_BIT_BANK_SELECT 0
// Writable bits of power control; bit 5 is reserved
`define CSFR_POWER_WMASK 8'hDF
// Writable bits of auxiliary control one
`define CSFR_AUX_WMASK 8'h01

`endif

// >>> verilog/csfr_pointer_bank.v
// Primary and alternate 16-bit data pointers with bank selection
`timescale 1ns/10ps

module csfr_pointer_bank #(
    parameter WIDTH = 16
) (
    // Clock and reset
    input wire clk,
    input wire rst,
    input wire ce,
    // Control
    input wire bank_sel,
    input wire wr_low,
    input wire wr_high,
    input wire [7:0] wdata,
    input wire load,
    input wire [WIDTH-1:0] load_value,
    // Active pointer
    output wire [WIDTH-1:0] ptr
);

    reg [WIDTH-1:0] ptr_q [0:1];

    // ==========================================================
    // One register per bank; only the selected bank is reached
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : g_bank
            // Bank 1 answers when the select bit is set, bank 0 otherwise
            wire hit = (g == 1) ? bank_sel : !bank_sel;
            always @(posedge clk or posedge rst) begin
                if (rst) begin
                    ptr_q[g] <= {WIDTH{1'b0}};
                end else if (ce && hit) begin
                    if (load) begin
                        ptr_q[g] <= load_value;
                    end else begin
                        if (wr_low) begin
                            ptr_q[g][7:0] <= wdata;
                        end
                        if (wr_high) begin
                            ptr_q[g][WIDTH-1:8] <= wdata;
                        end
                    end
                end
            end
        end
    endgenerate

    assign ptr = bank_sel ? ptr_q[1] : ptr_q[0];

endmodule // csfr_pointer_bank
